// ==== verilog/nibble_io_pkg.sv ====
// Constants for the nibble-wide port block
package nibble_io_pkg;

  // Bus geometry: index is byte address / 4
  localparam int          ADDR_W     = 16;
  localparam int          DATA_W     = 32;
  localparam int          IDX_W      = 12;
  localparam int          IDX_LSB    = 2;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;
  localparam logic [1:0]  STRB_LOW   = 2'h3;

  // Register indices
  localparam logic [11:0] IDX_SEG0   = 12'hFA2;
  localparam logic [11:0] IDX_SEG1   = 12'hFA3;
  localparam logic [11:0] IDX_SEG2   = 12'hFA4;
  localparam logic [11:0] IDX_SEG3   = 12'hFA5;
  localparam logic [11:0] IDX_PUS    = 12'hFE4;
  localparam logic [11:0] IDX_ODS4   = 12'hFE6;
  localparam logic [11:0] IDX_ODS5   = 12'hFE7;
  localparam logic [11:0] IDX_DIR0   = 12'hFEA;
  localparam logic [11:0] IDX_DIR1   = 12'hFEB;
  localparam logic [11:0] IDX_DIR4   = 12'hFEC;
  localparam logic [11:0] IDX_DIR5   = 12'hFED;
  localparam logic [11:0] IDX_DIR6   = 12'hFEE;
  localparam logic [11:0] IDX_DIR7   = 12'hFEF;
  localparam logic [11:0] IDX_PORT0  = 12'hFF0;
  localparam logic [11:0] IDX_PORT1  = 12'hFF1;
  localparam logic [11:0] IDX_PORT4  = 12'hFF4;
  localparam logic [11:0] IDX_PORT5  = 12'hFF5;
  localparam logic [11:0] IDX_PORT6  = 12'hFF6;
  localparam logic [11:0] IDX_PORT7  = 12'hFF7;

  // Write word fields
  localparam int          F_LO       = 0;
  localparam int          F_HI       = 4;
  localparam int          F_MASK     = 8;
  localparam int          F_SIZE     = 12;
  localparam logic [1:0]  SIZE_4     = 2'h0;
  localparam logic [1:0]  SIZE_8     = 2'h1;
  localparam logic [1:0]  SIZE_1     = 2'h2;

  // Geometry of ports and slots
  localparam int          NPINS      = 23;
  localparam int          NSEG       = 16;
  localparam int          NPORT      = 6;
  localparam int          NSLOT      = 10;
  localparam int          SLOT_P4    = 2;
  localparam int          SLOT_P5    = 3;
  localparam int          SLOT_P1    = 1;
  localparam int          SLOT_SEG   = 6;
  localparam int          PIN_BASE [NPORT] = '{0, 4, 7, 11, 15, 19};
  localparam int          PUS_BIT  [NPORT] = '{0, 0, 4, 5, 6, 7};
  localparam logic [3:0]  NIB_FULL   = 4'hF;
  localparam logic [3:0]  NIB_P1     = 4'h7;
  localparam logic [7:0]  PUS_MASK   = 8'hF1;

  // Reset values
  localparam logic [3:0]  RST_NIB    = 4'h0;
  localparam logic [7:0]  RST_BYTE   = 8'h00;

endpackage : nibble_io_pkg

// ==== verilog/nibble_io_port_block.sv ====
// General-purpose nibble port block with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none

module nibble_io_port_block
  import nibble_io_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [NPINS-1:0]   pin_in,
  output logic [NPINS-1:0]        pin_out,
  output logic [NPINS-1:0]        pin_oe_n,
  output logic [NPINS-1:0]        pullup_en,
  output logic [NSEG-1:0]         seg_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoders

  // Data and segment slots: {hit, slot}
  function automatic logic [4:0] data_slot(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_PORT0: data_slot = {1'b1, 4'd0};
      IDX_PORT1: data_slot = {1'b1, 4'd1};
      IDX_PORT4: data_slot = {1'b1, 4'd2};
      IDX_PORT5: data_slot = {1'b1, 4'd3};
      IDX_PORT6: data_slot = {1'b1, 4'd4};
      IDX_PORT7: data_slot = {1'b1, 4'd5};
      IDX_SEG0:  data_slot = {1'b1, 4'd6};
      IDX_SEG1:  data_slot = {1'b1, 4'd7};
      IDX_SEG2:  data_slot = {1'b1, 4'd8};
      IDX_SEG3:  data_slot = {1'b1, 4'd9};
      default:   data_slot = {1'b0, 4'd0};
    endcase
  endfunction : data_slot

  function automatic logic [4:0] dir_slot(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_DIR0: dir_slot = {1'b1, 4'd0};
      IDX_DIR1: dir_slot = {1'b1, 4'd1};
      IDX_DIR4: dir_slot = {1'b1, 4'd2};
      IDX_DIR5: dir_slot = {1'b1, 4'd3};
      IDX_DIR6: dir_slot = {1'b1, 4'd4};
      IDX_DIR7: dir_slot = {1'b1, 4'd5};
      default:  dir_slot = {1'b0, 4'd0};
    endcase
  endfunction : dir_slot

  // Bit access merges under mask, wider access replaces
  function automatic logic [3:0] merge(input logic [3:0] old, input logic [3:0] val,
                                       input logic [3:0] mask, input logic [1:0] size);
    merge = (size == SIZE_1) ? ((old & ~mask) | (val & mask)) : val;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [3:0]         bank_r [NSLOT];
  logic [3:0]         bank_nxt [NSLOT];
  logic [3:0]         dir_r [NPORT];
  logic [3:0]         dir_nxt [NPORT];
  logic [7:0]         pus_r;
  logic [7:0]         pus_nxt;
  logic [7:0]         ods_r;
  logic [7:0]         ods_nxt;
  logic [NPINS-1:0]   sync1_r;
  logic [NPINS-1:0]   sync2_r;
  logic               aw_have_r;
  logic               w_have_r;
  logic [ADDR_W-1:0]  awaddr_r;
  logic [DATA_W-1:0]  wdata_r;
  logic [3:0]         wstrb_r;
  logic               awready_r;
  logic               wready_r;
  logic               bvalid_r;
  logic [1:0]         bresp_r;
  logic               arready_r;
  logic               rvalid_r;
  logic [DATA_W-1:0]  rdata_r;
  logic [1:0]         rresp_r;
  logic [NPINS-1:0]   pin_out_r;
  logic [NPINS-1:0]   pin_oe_n_r;
  logic [NPINS-1:0]   pullup_en_r;
  logic [NSEG-1:0]    seg_out_r;
  logic [NPINS-1:0]   pin_out_nxt;
  logic [NPINS-1:0]   pin_oe_n_nxt;
  logic [NPINS-1:0]   pullup_en_nxt;
  logic [3:0]         view [NSLOT];

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  wire                aw_hs    = s_axi_awvalid & awready_r;
  wire                w_hs     = s_axi_wvalid & wready_r;
  wire                b_hs     = bvalid_r & s_axi_bready;
  wire                do_write = aw_have_r & w_have_r & ~bvalid_r;
  wire                w_align  = (awaddr_r[IDX_LSB-1:0] == '0) &&
                                 (awaddr_r[ADDR_W-1:IDX_W+IDX_LSB] == '0);
  wire [IDX_W-1:0]    w_idx    = awaddr_r[IDX_W+IDX_LSB-1:IDX_LSB];
  wire [4:0]          w_dslot  = data_slot(w_idx);
  wire [4:0]          w_rslot  = dir_slot(w_idx);
  wire [3:0]          w_lo     = wdata_r[F_LO+:4];
  wire [3:0]          w_hi     = wdata_r[F_HI+:4];
  wire [3:0]          w_mask   = wdata_r[F_MASK+:4];
  wire [1:0]          w_size   = wdata_r[F_SIZE+:2];
  wire                w_byte   = (w_size == SIZE_8);
  wire                w_strb   = (wstrb_r[1:0] == STRB_LOW);
  wire                w_en     = do_write & w_align & w_strb;
  wire                w_d_hit  = w_align & w_dslot[4];
  wire                w_r_hit  = w_align & w_rslot[4];
  wire                w_pus_hit = w_align & (w_idx == IDX_PUS);
  wire                w_ods_hit = w_align & ((w_idx == IDX_ODS4) || (w_idx == IDX_ODS5));
  wire                w_any_hit = w_d_hit | w_r_hit | w_pus_hit | w_ods_hit;
  wire                w_ods4_hit = w_align & (w_idx == IDX_ODS4);
  wire                w_pus_wr = w_en & w_pus_hit & w_byte;
  wire                w_ods_wr = w_en & w_ods4_hit & w_byte;

  // Pull-up select takes byte writes only, unused bits stay zero
  assign pus_nxt = w_pus_wr ? ({w_hi, w_lo} & PUS_MASK) : pus_r;

  // Open-drain select: one bit per pin of ports 4 and 5, byte writes at the port 4 location only
  assign ods_nxt = w_ods_wr ? {w_hi, w_lo} : ods_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  wire                ar_hs    = s_axi_arvalid & arready_r;
  wire                r_align  = (s_axi_araddr[IDX_LSB-1:0] == '0) &&
                                 (s_axi_araddr[ADDR_W-1:IDX_W+IDX_LSB] == '0);
  wire [IDX_W-1:0]    r_idx    = s_axi_araddr[IDX_W+IDX_LSB-1:IDX_LSB];
  wire [4:0]          r_dslot  = data_slot(r_idx);
  wire [4:0]          r_rslot  = dir_slot(r_idx);
  wire [3:0]          r_dsn    = r_dslot[3:0] + 4'd1;
  wire [3:0]          r_rsn    = r_rslot[3:0] + 4'd1;
  wire                r_dpair  = ~r_dslot[0];
  wire                r_rpair  = ~r_rslot[0];
  // Odd slots have no upper partner; keep the index in range
  wire [3:0]          r_dnx    = r_dpair ? r_dsn : r_dslot[3:0];
  wire [2:0]          r_rnx    = r_rpair ? r_rsn[2:0] : r_rslot[2:0];
  wire [7:0]          r_dval   = {r_dpair ? view[r_dnx] : RST_NIB, view[r_dslot[3:0]]};
  wire [7:0]          r_rval   = {r_rpair ? dir_r[r_rnx] : RST_NIB, dir_r[r_rslot[2:0]]};
  wire                r_d_hit  = r_align & r_dslot[4];
  wire                r_r_hit  = r_align & r_rslot[4];
  wire                r_pus_hit = r_align & (r_idx == IDX_PUS);
  wire                r_ods_hit = r_align & ((r_idx == IDX_ODS4) || (r_idx == IDX_ODS5));
  // Port 5 location shows its nibble alone
  wire [7:0]          r_ods    = (r_idx == IDX_ODS4) ? ods_r : {RST_NIB, ods_r[7:4]};
  wire [7:0]          r_byte   = r_d_hit   ? r_dval :
                                 r_r_hit   ? r_rval :
                                 r_pus_hit ? pus_r :
                                 r_ods_hit ? r_ods :
                                 RST_BYTE;
  wire                r_any_hit = r_d_hit | r_r_hit | r_pus_hit | r_ods_hit;

  // Segment pins gather the four output locations
  wire [NSEG-1:0]     seg_nxt  = {bank_r[SLOT_SEG+3], bank_r[SLOT_SEG+2], bank_r[SLOT_SEG+1], bank_r[SLOT_SEG]};

  ////////////////////////////////////////////////////////////////////////////
  // Per-slot latches, pin mapping and read view

  genvar i, j;
  generate
    for (i = 0; i < NSLOT; i++) begin : g_slot
      localparam logic [3:0] VALID = (i == SLOT_P1) ? NIB_P1 : NIB_FULL;
      wire hit_lo = w_en & w_d_hit & (w_dslot[3:0] == i);
      wire hit_hi = w_en & w_d_hit & w_byte & ~w_dslot[0] & (w_dslot[3:0] == i - 1);
      // Output latch written in either direction mode
      assign bank_nxt[i] = hit_lo ? (merge(bank_r[i], w_lo, w_mask, w_size) & VALID) :
                           hit_hi ? (w_hi & VALID) : bank_r[i];
      if (i >= SLOT_SEG) begin : g_segview
        assign view[i] = bank_r[i];
      end else begin : g_portview
        for (j = 0; j < 4; j++) begin : g_bit
          if (i == SLOT_P1 && j == 3) begin : g_none
            assign view[i][j] = 1'b0;
          end else begin : g_pin
            localparam int P = PIN_BASE[i] + j;
            wire od_release;
            // Output pins read back the latch, inputs read the pin
            assign view[i][j] = dir_r[i][j] ? bank_r[i][j] : sync2_r[P];
            // Open-drain releases the pin on a one; only ports 4 and 5 have it
            if (i == SLOT_P4 || i == SLOT_P5) begin : g_od
              assign od_release = ods_r[(i - SLOT_P4) * 4 + j] & bank_r[i][j];
            end else begin : g_pp
              assign od_release = 1'b0;
            end
            assign pin_out_nxt[P]   = bank_r[i][j];
            assign pin_oe_n_nxt[P]  = ~(dir_r[i][j] & ~od_release);
            assign pullup_en_nxt[P] = pus_r[PUS_BIT[i]] & ~dir_r[i][j];
          end
        end
      end
    end

    // Direction flags, ports 4 and 5 as whole nibbles
    for (i = 0; i < NPORT; i++) begin : g_dir
      localparam logic [3:0] VALID = (i == SLOT_P1) ? NIB_P1 : NIB_FULL;
      wire        hit_lo = w_en & w_r_hit & (w_rslot[3:0] == i);
      wire        hit_hi = w_en & w_r_hit & w_byte & ~w_rslot[0] & (w_rslot[3:0] == i - 1);
      wire [3:0]  raw    = hit_lo ? merge(dir_r[i], w_lo, w_mask, w_size) : w_hi;
      if (i == SLOT_P4 || i == SLOT_P5) begin : g_nib
        // Whole nibble follows bit 0
        assign dir_nxt[i] = (hit_lo | hit_hi) ? {4{raw[0]}} : dir_r[i];
      end else begin : g_bitdir
        assign dir_nxt[i] = (hit_lo | hit_hi) ? (raw & VALID) : dir_r[i];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < NSLOT; k++) bank_r[k] <= RST_NIB;
      for (int k = 0; k < NPORT; k++) dir_r[k] <= RST_NIB;
      pus_r <= RST_BYTE;
      ods_r <= RST_BYTE;
    end else if (ce) begin
      for (int k = 0; k < NSLOT; k++) bank_r[k] <= bank_nxt[k];
      for (int k = 0; k < NPORT; k++) dir_r[k] <= dir_nxt[k];
      pus_r <= pus_nxt;
      ods_r <= ods_nxt;
    end
  end

  // Pin input synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else if (ce) begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // Registered pin and segment drive, buffers off in reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_r   <= '0;
      pin_oe_n_r  <= '1;
      pullup_en_r <= '0;
      seg_out_r   <= '0;
    end else if (ce) begin
      pin_out_r   <= pin_out_nxt;
      pin_oe_n_r  <= pin_oe_n_nxt;
      pullup_en_r <= pullup_en_nxt;
      seg_out_r   <= seg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else if (ce) begin
      // Address and data may arrive in either order
      if (aw_hs) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
        awready_r <= 1'b0;
      end else if (do_write) begin
        aw_have_r <= 1'b0;
      end
      if (w_hs) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        wready_r <= 1'b0;
      end else if (do_write) begin
        w_have_r <= 1'b0;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r  <= w_any_hit ? RESP_OKAY : RESP_DECERR;
      end else if (b_hs) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channels

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= {{(DATA_W-8){1'b0}}, r_byte};
        rresp_r   <= r_any_hit ? RESP_OKAY : RESP_DECERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign pin_out       = pin_out_r;
  assign pin_oe_n      = pin_oe_n_r;
  assign pullup_en     = pullup_en_r;
  assign seg_out       = seg_out_r;

endmodule : nibble_io_port_block

`default_nettype wire

// ==== verif/pin_board_model.sv ====
// Board side of the port pins: drivers, pull-ups and floating lines
`timescale 1ns/1ns
`default_nettype none
module pin_board_model
  import nibble_io_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic [NPINS-1:0] pin_out,
  input  wire logic [NPINS-1:0] pin_oe_n,
  input  wire logic [NPINS-1:0] pullup_en,
  input  wire logic [NPINS-1:0] ext_val,
  input  wire logic [NPINS-1:0] ext_en,
  output logic      [NPINS-1:0] pin_in
);
  logic [NPINS-1:0] float_r = '0;
  // Undriven line without pull-up wanders
  always @(posedge aclk) float_r <= ~float_r;
  // Released open-drain pin falls back to board or float
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & (pullup_en | float_r));
endmodule : pin_board_model
`default_nettype wire

// ==== verif/nibble_io_port_block_assertions.sv ====
// Port-level checker for the nibble port block
`timescale 1ns/1ns
`default_nettype none
module nibble_io_checker
  import nibble_io_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [NPINS-1:0]  pin_oe_n,
  input wire logic [NPINS-1:0]  pullup_en,
  input wire logic [NSEG-1:0]   seg_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RESET_OUTS: assert property ($rose(aresetn) |-> &pin_oe_n && seg_out == '0 && pullup_en == '0)
    else $error("pin outputs not cleared by reset");
  AST_PULLUP_OFF: assert property ((pullup_en & ~pin_oe_n) == '0)
    else $error("pull-up on a driven pin");
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read response late");
  AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data above one byte");
  AST_SEG_CAUSE: assert property ($changed(seg_out) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("segment pins moved without a write");
endmodule : nibble_io_checker
bind nibble_io_port_block nibble_io_checker i_nibble_io_checker (.aclk, .aresetn, .ce, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .pin_oe_n, .pullup_en, .seg_out);
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the nibble port block
`timescale 1ns/1ns
`default_nettype none
module testbench
  import nibble_io_pkg::*;
;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_awready;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_arready;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready = 1'b0;
  logic [NPINS-1:0]  pin_in;
  logic [NPINS-1:0]  pin_out;
  logic [NPINS-1:0]  pin_oe_n;
  logic [NPINS-1:0]  pullup_en;
  logic [NPINS-1:0]  ext_val = '0;
  logic [NPINS-1:0]  ext_en = '1;
  logic [NSEG-1:0]   seg_out;
  int                failures = 0;
  int                n_tests = 0;
  nibble_io_port_block i_nibble_io_port_block (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
    .pin_oe_n, .pullup_en, .seg_out);
  pin_board_model i_pin_board_model (.aclk, .pin_out, .pin_oe_n, .pullup_en, .ext_val, .ext_en, .pin_in);
  initial forever #25 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [ADDR_W-1:0] ba(input logic [11:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : ba
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    // Ready stays up between calls
    chk(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rresp, er);
    if (er === RESP_OKAY) chk(s_axi_rdata, exp);
  endtask : rd
  task automatic do_reset();
    aresetn <= 1'b0;
    wt(4);
    aresetn <= 1'b1;
    wt(1);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////
  task automatic t_reset_state();
    logic [11:0] idx [6] = '{IDX_DIR0, IDX_DIR4, IDX_DIR6, IDX_PUS, IDX_ODS4, IDX_PORT0};
    foreach (idx[i]) rd(ba(idx[i]), 32'h0, RESP_OKAY);
    chk(pin_oe_n, 23'h7FFFFF);
    chk(pin_out | pullup_en, 23'h0);
    chk(seg_out, 16'h0);
    $display("test reset_state done");
  endtask : t_reset_state
  task automatic t_port0_dir();
    wr(ba(IDX_DIR0), 32'h5, RESP_OKAY);
    wr(ba(IDX_PORT0), 32'hF, RESP_OKAY);
    wt(2);
    chk(pin_oe_n[3:0], 4'hA);
    chk(pin_out[3:0], 4'hF);
    rd(ba(IDX_PORT0), 32'h5, RESP_OKAY);
    $display("test port0_dir done");
  endtask : t_port0_dir
  task automatic t_clock_enable();
    ext_val[3:0] <= 4'h2;
    ce <= 1'b0;
    wt(4);
    ce <= 1'b1;
    // Synchroniser frozen while disabled: old pin level first
    rd(ba(IDX_PORT0), 32'h5, RESP_OKAY);
    wt(2);
    rd(ba(IDX_PORT0), 32'h7, RESP_OKAY);
    ext_val[3:0] <= 4'h0;
    $display("test clock_enable done");
  endtask : t_clock_enable
  task automatic t_port4_od();
    wr(ba(IDX_DIR4), 32'h1, RESP_OKAY);
    wr(ba(IDX_PORT4), 32'hF, RESP_OKAY);
    wt(2);
    chk(pin_oe_n[10:7], 4'h0);
    wr(ba(IDX_ODS4), 32'h5, RESP_OKAY);
    rd(ba(IDX_ODS4), 32'h0, RESP_OKAY);
    wr(ba(IDX_ODS4), 32'h1005, RESP_OKAY);
    wt(2);
    chk(pin_oe_n[10:7], 4'h5);
    rd(ba(IDX_ODS4), 32'h5, RESP_OKAY);
    rd(ba(IDX_PORT4), 32'hF, RESP_OKAY);
    $display("test port4_od done");
  endtask : t_port4_od
  task automatic t_pullup();
    wr(ba(IDX_PUS), 32'hFF, RESP_OKAY);
    rd(ba(IDX_PUS), 32'h0, RESP_OKAY);
    wr(ba(IDX_PUS), 32'h10FF, RESP_OKAY);
    rd(ba(IDX_PUS), 32'hF1, RESP_OKAY);
    wt(2);
    chk(pullup_en, {4'hF, 4'hF, 4'hF, 4'h0, 3'h7, 4'hA});
    ext_en[22:19] <= 4'h0;
    wt(5);
    rd(ba(IDX_PORT7), 32'hF, RESP_OKAY);
    $display("test pullup done");
  endtask : t_pullup
  task automatic t_bit_write();
    wr(ba(IDX_DIR6), 32'h100F, RESP_OKAY);
    wr(ba(IDX_PORT6), 32'h2404, RESP_OKAY);
    wt(2);
    chk(pin_out[18:15], 4'h4);
    rd(ba(IDX_PORT6), 32'hF4, RESP_OKAY);
    wr(ba(IDX_PORT6), 32'h2101, RESP_OKAY);
    wt(2);
    chk(pin_out[18:15], 4'h5);
    chk({pin_oe_n[18:15], pullup_en[18:15]}, 8'h00);
    $display("test bit_write done");
  endtask : t_bit_write
  task automatic t_segment();
    wr(ba(IDX_SEG0), 32'h1021, RESP_OKAY);
    wr(ba(IDX_SEG2), 32'h1043, RESP_OKAY);
    wt(2);
    chk(seg_out, 16'h4321);
    wr(ba(IDX_SEG3), 32'hC, RESP_OKAY);
    wt(2);
    chk(seg_out, 16'hC321);
    rd(ba(IDX_SEG1), 32'h2, RESP_OKAY);
    $display("test segment done");
  endtask : t_segment
  task automatic t_decerr();
    wr(16'h0000, 32'h1, RESP_DECERR);
    rd(ba(IDX_PORT0) | 16'h0001, 32'h0, RESP_DECERR);
    rd(ba(12'hFF2), 32'h0, RESP_DECERR);
    $display("test decerr done");
  endtask : t_decerr
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_reset_state();
    t_port0_dir();
    t_clock_enable();
    t_port4_od();
    t_pullup();
    t_bit_write();
    t_segment();
    t_decerr();
    do_reset();
    t_reset_state();
    end_sim();
  end
  initial begin
    wt(20000);
    failures++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
